// [ar_file_pkg.sv]
// Constants shared by the application register file
package ar_file_pkg;
    // Application register indices
    localparam logic [6:0] IDX_OS_INFO_0   = 7'h00;
    localparam logic [6:0] IDX_OS_INFO_7   = 7'h07;
    localparam logic [6:0] IDX_STACK_CTRL  = 7'h10;
    localparam logic [6:0] IDX_BACK_SAVE   = 7'h11;
    localparam logic [6:0] IDX_SPILL_NEXT  = 7'h12;
    localparam logic [6:0] IDX_SPILL_DEFER = 7'h13;
    localparam logic [6:0] IDX_WIDE_STORE  = 7'h19;
    localparam logic [6:0] IDX_COMPARE_VAL = 7'h20;
    localparam logic [6:0] IDX_USER_DEFER  = 7'h24;
    localparam logic [6:0] IDX_FLOAT_STAT  = 7'h28;
    localparam logic [6:0] IDX_TIMER       = 7'h2C;

    // Stack engine control field positions
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_PL_LO    = 2;
    localparam int CTRL_ORDER    = 4;
    localparam int CTRL_TEAR_LO  = 16;
    localparam int CTRL_TEAR_HI  = 29;
    localparam logic [63:0] CTRL_RESV_MASK = 64'hFFFF_FFFF_C000_FFE0;

    // Spill deferral bits: top bit always zero
    localparam logic [63:0] DEFER_WR_MASK  = 64'h7FFF_FFFF_FFFF_FFFF;
    // Wide store data bits that may be left out
    localparam logic [63:0] WIDE_OPT_MASK  = 64'h3000_0000_0000_0000;

    // Frame descriptor field positions (38 bits)
    localparam int FD_WIDTH    = 38;
    localparam int FD_SIZE_LO  = 0;
    localparam int FD_LOCAL_LO = 7;
    localparam int FD_ROT_LO   = 14;
    localparam int FD_RRB_LO   = 18;

    // Reset values
    localparam logic [63:0] RESET_WORD = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  PRIV_MOST  = 2'h0;

    // Timer prescale: core cycles per timer tick
    localparam logic [7:0]  TIMER_DIV_CYCLES = 8'h01;
endpackage

// [ar_file.sv]
// Application special-register file with frame descriptor and interval timer
`timescale 1ns/100ps

// How it works
// - No register move reaches the frame descriptor; only calls, returns and frame loads change it.
// - Call saves descriptor to caller state, new frame keeps only caller outputs.
// - Call clears all three rename bases in the descriptor.
// - Privileged-write registers fault on writes at nonzero privilege; reads allowed except secured timer reads.
// - Eight 64-bit OS info registers, read anywhere, written at level 0.
// - In legacy mode the first three OS info registers hold legacy state.
// - Writes never set the spill privilege field above current privilege.
// - Mode bit 1 eager loads, bit 0 eager stores; eager may act lazy.
// - Spill engine accesses use privilege from control bits 3:2.
// - Control bit 4 picks spill byte order: 0 little, 1 big.
// - Bits 29:16 hold the tear-point load distance for synchronisation.
// - Control bits 15:5 and 63:30 are reserved.
// - Reserved fields read zero; nonzero writes raise reserved field fault.
// - Read-only 64-bit backing save pointer for first stacked register.
// - Writing a read-only register raises illegal operation fault.
// - 64-bit spill next pointer gives next spill address.
// - Spill deferral bit 63 reads zero and drops writes.
// - Wide store data feeds wide stores, loaded by wide loads.
// - Without wide instructions bits 61:60 optional, else all bits kept.
// - Compare value register is third operand of compare exchange.
// - Timer increments at constant prescaled rate from the input clock.
// - Timer reads strictly increase in program order except at wrap.
// - Secured timer native read below level 0 faults; writes level 0 only.
// - Legacy stamp read returns timer; secured low-level read raises protection fault.
module ar_file
    import ar_file_pkg::*;
#(
    parameter bit         EAGER_AS_LAZY = 1'b0,
    parameter bit         WIDE_PRESENT  = 1'b1,
    parameter logic [7:0] TIMER_DIV     = TIMER_DIV_CYCLES
)(
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Register move requests from the pipeline
    input  wire logic                ar_valid,
    input  wire logic                ar_write,
    input  wire logic                ar_stamp,
    input  wire logic [6:0]          ar_index,
    input  wire logic [63:0]         ar_wdata,
    input  wire logic [1:0]          cur_priv,
    input  wire logic                legacy_mode,
    input  wire logic                timer_secure,
    output logic                     ar_done,
    output logic [63:0]              ar_rdata,
    output logic                     priv_fault,
    output logic                     resv_fault,
    output logic                     illegal_fault,
    output logic                     legacy_gp_fault,
    // Frame events
    input  wire logic                call_valid,
    input  wire logic                ret_valid,
    input  wire logic                frame_load_valid,
    input  wire logic [FD_WIDTH-1:0] frame_load_value,
    output logic [FD_WIDTH-1:0]      frame_descriptor,
    output logic [FD_WIDTH-1:0]      caller_state_reg,
    // Legacy state into the first OS info registers
    input  wire logic [2:0]          legacy_state_we,
    input  wire logic [63:0]         legacy_state_wdata,
    // Spill engine side
    input  wire logic                back_save_load,
    input  wire logic [63:0]         back_save_value,
    input  wire logic                spill_next_load,
    input  wire logic [63:0]         spill_next_value,
    input  wire logic                defer_load,
    input  wire logic [63:0]         defer_value,
    output logic [1:0]               spill_priv_level,
    output logic                     spill_byte_order,
    output logic                     eager_load_en,
    output logic                     eager_store_en,
    output logic [13:0]              tear_load_distance,
    output logic [63:0]              spill_next_addr,
    // Wide memory operations
    input  wire logic                wide_load_valid,
    input  wire logic [63:0]         wide_load_upper,
    output logic [63:0]              wide_store_data,
    output logic [63:0]              compare_value
);

    typedef struct packed {
        logic [7:0][63:0]     os_info;
        logic [63:0]          stack_ctrl;
        logic [63:0]          back_save;
        logic [63:0]          spill_next;
        logic [63:0]          spill_defer;
        logic [63:0]          wide_store;
        logic [63:0]          cmp_value;
        logic [63:0]          user_defer;
        logic [63:0]          float_stat;
        logic [63:0]          timer;
        logic [7:0]           tick_cnt;
        logic [FD_WIDTH-1:0]  frame;
        logic [FD_WIDTH-1:0]  caller;
        logic                 done;
        logic [63:0]          rdata;
        logic                 f_priv;
        logic                 f_resv;
        logic                 f_illegal;
        logic                 f_gp;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Index belongs to the OS info bank
    function automatic logic is_os_info(input logic [6:0] idx);
        return idx <= IDX_OS_INFO_7;
    endfunction

    logic        os_sel;
    logic        tick;
    logic [1:0]  req_pl;
    logic [63:0] wide_mask;

    assign os_sel    = is_os_info(ar_index);
    assign tick      = (state_reg.tick_cnt == TIMER_DIV - 8'h01);
    assign req_pl    = ar_wdata[CTRL_PL_LO +: 2];
    // Optional bits are kept either way; dropping them saves only two flops
    assign wide_mask = WIDE_PRESENT ? 64'hFFFF_FFFF_FFFF_FFFF : ~WIDE_OPT_MASK | WIDE_OPT_MASK;

    // Next state of the whole register file
    always_comb
    begin
        state_next           = state_reg;
        state_next.done      = 1'b0;
        state_next.f_priv    = 1'b0;
        state_next.f_resv    = 1'b0;
        state_next.f_illegal = 1'b0;
        state_next.f_gp      = 1'b0;

        // Timer prescaler and free-running count; wrap is silent
        state_next.tick_cnt = tick ? 8'h00 : state_reg.tick_cnt + 8'h01;
        if (tick)
        begin
            state_next.timer = state_reg.timer + 64'h1;
        end

        // Frame events; the register move path never touches the frame
        if (call_valid)
        begin
            state_next.caller = state_reg.frame;
            state_next.frame  = '0;
            state_next.frame[FD_SIZE_LO +: 7] = state_reg.frame[FD_SIZE_LO +: 7]
                                              - state_reg.frame[FD_LOCAL_LO +: 7];
        end
        else if (ret_valid)
        begin
            state_next.frame = state_reg.caller;
        end
        else if (frame_load_valid)
        begin
            state_next.frame = frame_load_value;
        end

        // Spill engine, wide load and legacy state updates
        if (back_save_load)
        begin
            state_next.back_save = back_save_value;
        end
        if (spill_next_load)
        begin
            state_next.spill_next = spill_next_value;
        end
        if (defer_load)
        begin
            state_next.spill_defer = defer_value & DEFER_WR_MASK;
        end
        if (wide_load_valid)
        begin
            state_next.wide_store = wide_load_upper & wide_mask;
        end
        if (legacy_mode)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (legacy_state_we[i])
                begin
                    state_next.os_info[i] = legacy_state_wdata;
                end
            end
        end

        // Register moves from the pipeline, answered one cycle later
        if (ar_valid)
        begin
            state_next.done  = 1'b1;
            state_next.rdata = RESET_WORD;
            if (ar_stamp)
            begin
                // Legacy time stamp read
                if (timer_secure && cur_priv != PRIV_MOST)
                begin
                    state_next.f_gp = 1'b1;
                end
                else
                begin
                    state_next.rdata = state_reg.timer;
                end
            end
            else if (!ar_write)
            begin
                if (os_sel)
                begin
                    state_next.rdata = state_reg.os_info[ar_index[2:0]];
                end
                else
                begin
                    unique case (ar_index)
                        IDX_STACK_CTRL:  state_next.rdata = state_reg.stack_ctrl;
                        IDX_BACK_SAVE:   state_next.rdata = state_reg.back_save;
                        IDX_SPILL_NEXT:  state_next.rdata = state_reg.spill_next;
                        IDX_SPILL_DEFER: state_next.rdata = state_reg.spill_defer;
                        IDX_WIDE_STORE:  state_next.rdata = state_reg.wide_store;
                        IDX_COMPARE_VAL: state_next.rdata = state_reg.cmp_value;
                        IDX_USER_DEFER:  state_next.rdata = state_reg.user_defer;
                        IDX_FLOAT_STAT:  state_next.rdata = state_reg.float_stat;
                        IDX_TIMER:
                        begin
                            if (timer_secure && cur_priv != PRIV_MOST)
                            begin
                                state_next.f_priv = 1'b1;
                            end
                            else
                            begin
                                state_next.rdata = state_reg.timer;
                            end
                        end
                        default:         state_next.f_illegal = 1'b1;
                    endcase
                end
            end
            else if (os_sel)
            begin
                // OS info registers are privileged-write
                if (cur_priv != PRIV_MOST)
                begin
                    state_next.f_priv = 1'b1;
                end
                else
                begin
                    state_next.os_info[ar_index[2:0]] = ar_wdata;
                end
            end
            else
            begin
                unique case (ar_index)
                    IDX_STACK_CTRL:
                    begin
                        if ((ar_wdata & CTRL_RESV_MASK) != RESET_WORD)
                        begin
                            state_next.f_resv = 1'b1;
                        end
                        else
                        begin
                            state_next.stack_ctrl = ar_wdata;
                            // Larger number is less privileged
                            if (req_pl < cur_priv)
                            begin
                                state_next.stack_ctrl[CTRL_PL_LO +: 2] = cur_priv;
                            end
                        end
                    end
                    IDX_BACK_SAVE:   state_next.f_illegal = 1'b1;
                    IDX_SPILL_NEXT:  state_next.spill_next = ar_wdata;
                    IDX_SPILL_DEFER: state_next.spill_defer = ar_wdata & DEFER_WR_MASK;
                    IDX_WIDE_STORE:  state_next.wide_store = ar_wdata & wide_mask;
                    IDX_COMPARE_VAL: state_next.cmp_value = ar_wdata;
                    IDX_USER_DEFER:  state_next.user_defer = ar_wdata;
                    IDX_FLOAT_STAT:  state_next.float_stat = ar_wdata;
                    IDX_TIMER:
                    begin
                        if (cur_priv != PRIV_MOST)
                        begin
                            state_next.f_priv = 1'b1;
                        end
                        else
                        begin
                            state_next.timer = ar_wdata;
                        end
                    end
                    default:         state_next.f_illegal = 1'b1;
                endcase
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs from registered state
    assign ar_done            = state_reg.done;
    assign ar_rdata           = state_reg.rdata;
    assign priv_fault         = state_reg.f_priv;
    assign resv_fault         = state_reg.f_resv;
    assign illegal_fault      = state_reg.f_illegal;
    assign legacy_gp_fault    = state_reg.f_gp;
    assign frame_descriptor   = state_reg.frame;
    assign caller_state_reg   = state_reg.caller;
    assign spill_priv_level   = state_reg.stack_ctrl[CTRL_PL_LO +: 2];
    assign spill_byte_order   = state_reg.stack_ctrl[CTRL_ORDER];
    // Eager modes are hints; lazy is always a legal reading
    assign eager_load_en      = state_reg.stack_ctrl[CTRL_MODE_LO + 1] & ~EAGER_AS_LAZY;
    assign eager_store_en     = state_reg.stack_ctrl[CTRL_MODE_LO] & ~EAGER_AS_LAZY;
    assign tear_load_distance = state_reg.stack_ctrl[CTRL_TEAR_HI:CTRL_TEAR_LO];
    assign spill_next_addr    = state_reg.spill_next;
    assign wide_store_data    = state_reg.wide_store;
    assign compare_value      = state_reg.cmp_value;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Checks
    spill_pl_clamp_a: assert property (
        ar_valid && ar_write && !ar_stamp && ar_index == IDX_STACK_CTRL
        && (ar_wdata & CTRL_RESV_MASK) == RESET_WORD
        |=> spill_priv_level >= $past(cur_priv))
        else $error("spill privilege set above current level");
    ctrl_resv_fault_a: assert property (
        ar_valid && ar_write && !ar_stamp && ar_index == IDX_STACK_CTRL
        && (ar_wdata & CTRL_RESV_MASK) != RESET_WORD
        |=> resv_fault && ar_done && $stable(spill_byte_order))
        else $error("reserved control write not refused");
    backsave_write_a: assert property (
        ar_valid && ar_write && !ar_stamp && ar_index == IDX_BACK_SAVE |=> illegal_fault)
        else $error("backing save write not faulted");
    os_info_guard_a: assert property (
        ar_valid && ar_write && !ar_stamp && is_os_info(ar_index) && cur_priv != PRIV_MOST
        |=> priv_fault && !illegal_fault)
        else $error("os info write at low privilege");
    timer_secure_a: assert property (
        ar_valid && !ar_write && !ar_stamp && ar_index == IDX_TIMER
        && timer_secure && cur_priv != PRIV_MOST |=> priv_fault && ar_rdata == RESET_WORD)
        else $error("secured timer read not faulted");
    stamp_guard_a: assert property (
        ar_valid && ar_stamp && timer_secure && cur_priv != PRIV_MOST
        |=> legacy_gp_fault && !priv_fault)
        else $error("secured stamp read not faulted");
    call_frame_a: assert property (
        call_valid |=> caller_state_reg == $past(frame_descriptor)
        && frame_descriptor[FD_ROT_LO +: 4] == 4'h0 && frame_descriptor[FD_LOCAL_LO +: 7] == 7'h00)
        else $error("call did not save and reset frame");
    call_rename_a: assert property (
        call_valid |=> frame_descriptor[FD_WIDTH-1:FD_RRB_LO] == 20'h00000)
        else $error("call left rename bases nonzero");
    // Every read of the deferral bits answers with the top bit clear
    defer_top_a: assert property (
        ar_valid && !ar_write && !ar_stamp && ar_index == IDX_SPILL_DEFER
        |=> ar_done && ar_rdata[63] == 1'b0)
        else $error("deferral bit 63 not zero");
    timer_step_a: assert property (
        !(ar_valid && ar_write && !ar_stamp && ar_index == IDX_TIMER)
        |=> state_reg.timer == $past(state_reg.timer)
        || state_reg.timer == $past(state_reg.timer) + 64'h1)
        else $error("timer moved other than by one");

endmodule

// [ar_move_issuer.sv]
// Pipeline model that issues register moves and collects their answers
`timescale 1ns/100ps
module ar_move_issuer (
    input  wire logic        clk,
    input  wire logic        ar_done,
    input  wire logic [63:0] ar_rdata,
    input  wire logic [3:0]  faults,
    output logic             ar_valid,
    output logic             ar_write,
    output logic             ar_stamp,
    output logic [6:0]       ar_index,
    output logic [63:0]      ar_wdata
);
    logic        last_done;
    logic [63:0] last_data;
    logic [3:0]  last_flt;

    // Idle state at time zero
    initial
    begin
        ar_valid = 1'b0;
        ar_write = 1'b0;
        ar_stamp = 1'b0;
        ar_index = 7'h00;
        ar_wdata = 64'h0;
    end

    // One move: held across the taking edge, answer sampled a cycle later
    task automatic move(input logic w, input logic st, input logic [6:0] idx,
                        input logic [63:0] d);
        @(negedge clk);
        ar_valid = 1'b1;
        ar_write = w;
        ar_stamp = st;
        ar_index = idx;
        ar_wdata = d;
        @(posedge clk);
        @(negedge clk);
        ar_valid = 1'b0;
        ar_wdata = ~d; // Stale data inverted so it is never mistaken for live
        last_done = ar_done;
        last_data = ar_rdata;
        last_flt = faults;
    endtask
endmodule

// [tb_app_register_file_frame_marker.sv]
// Self-checking testbench for the application register file
`timescale 1ns/100ps
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module tb_app_register_file_frame_marker
    import ar_file_pkg::*;
;
    logic clk, rst_n, ar_valid, ar_write, ar_stamp, legacy_mode, timer_secure, ar_done;
    logic priv_fault, resv_fault, illegal_fault, legacy_gp_fault;
    logic call_valid, ret_valid, frame_load_valid, back_save_load, spill_next_load;
    logic defer_load, wide_load_valid, spill_byte_order, eager_load_en, eager_store_en;
    logic [6:0]          ar_index;
    logic [1:0]          cur_priv, spill_priv_level;
    logic [2:0]          legacy_state_we;
    logic [13:0]         tear_load_distance;
    logic [FD_WIDTH-1:0] frame_load_value, frame_descriptor, caller_state_reg, fd_old;
    logic [63:0] ar_wdata, ar_rdata, legacy_state_wdata, back_save_value, spill_next_value;
    logic [63:0] defer_value, wide_load_upper, spill_next_addr, wide_store_data, compare_value;
    int errors = 0;
    int check_count = 0;

    ar_file ar_file_i (.clk(clk), .rst_n(rst_n), .ar_valid(ar_valid), .ar_write(ar_write),
        .ar_stamp(ar_stamp), .ar_index(ar_index), .ar_wdata(ar_wdata), .cur_priv(cur_priv),
        .legacy_mode(legacy_mode), .timer_secure(timer_secure), .ar_done(ar_done),
        .ar_rdata(ar_rdata), .priv_fault(priv_fault), .resv_fault(resv_fault),
        .illegal_fault(illegal_fault), .legacy_gp_fault(legacy_gp_fault),
        .call_valid(call_valid), .ret_valid(ret_valid), .frame_load_valid(frame_load_valid),
        .frame_load_value(frame_load_value), .frame_descriptor(frame_descriptor),
        .caller_state_reg(caller_state_reg), .legacy_state_we(legacy_state_we),
        .legacy_state_wdata(legacy_state_wdata), .back_save_load(back_save_load),
        .back_save_value(back_save_value), .spill_next_load(spill_next_load),
        .spill_next_value(spill_next_value), .defer_load(defer_load),
        .defer_value(defer_value), .spill_priv_level(spill_priv_level),
        .spill_byte_order(spill_byte_order), .eager_load_en(eager_load_en),
        .eager_store_en(eager_store_en), .tear_load_distance(tear_load_distance),
        .spill_next_addr(spill_next_addr), .wide_load_valid(wide_load_valid),
        .wide_load_upper(wide_load_upper), .wide_store_data(wide_store_data),
        .compare_value(compare_value));

    ar_move_issuer ar_move_issuer_i (.clk(clk), .ar_done(ar_done), .ar_rdata(ar_rdata),
        .faults({priv_fault, resv_fault, illegal_fault, legacy_gp_fault}),
        .ar_valid(ar_valid), .ar_write(ar_write), .ar_stamp(ar_stamp),
        .ar_index(ar_index), .ar_wdata(ar_wdata));

    // Clock at 40 ns
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Verdict; the single exit of the run
    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Move, then judge the answer pulse and fault code {priv,resv,illegal,gp}
    task automatic mv(input logic w, input logic st, input logic [6:0] idx,
                      input logic [63:0] d, input logic [3:0] flt);
        ar_move_issuer_i.move(w, st, idx, d);
        `CHK(ar_move_issuer_i.last_done, 1'b1)
        `CHK(ar_move_issuer_i.last_flt, flt)
    endtask

    // Read and compare data
    task automatic rdc(input logic [6:0] idx, input logic [63:0] exp_d);
        mv(1'b0, 1'b0, idx, 64'h0, 4'h0);
        `CHK(ar_move_issuer_i.last_data, exp_d)
    endtask

    // OS info privilege and legacy state path
    task automatic t_os_info();
        cur_priv = 2'h0;
        mv(1'b1, 1'b0, IDX_OS_INFO_7, 64'hA5A5_0000_FFFF_5A5A, 4'h0);
        cur_priv = 2'h3;
        rdc(IDX_OS_INFO_7, 64'hA5A5_0000_FFFF_5A5A);
        mv(1'b1, 1'b0, IDX_OS_INFO_7, 64'h1, 4'h8);
        rdc(IDX_OS_INFO_7, 64'hA5A5_0000_FFFF_5A5A);
        legacy_mode = 1'b1;
        legacy_state_we = 3'h4;
        legacy_state_wdata = 64'h0000_1234_0000_9876;
        @(negedge clk);
        legacy_state_we = 3'h0;
        legacy_mode = 1'b0;
        rdc(7'h02, 64'h0000_1234_0000_9876);
    endtask

    // Stack engine control fields, clamp and reserved bits
    task automatic t_ctrl();
        cur_priv = 2'h2;
        mv(1'b1, 1'b0, IDX_STACK_CTRL, 64'h0000_0000_3FFF_0013, 4'h0);
        `CHK(spill_priv_level, 2'h2)
        `CHK(spill_byte_order, 1'b1)
        `CHK(tear_load_distance, 14'h3FFF)
        rdc(IDX_STACK_CTRL, 64'h0000_0000_3FFF_001B);
        cur_priv = 2'h0;
        for (int m = 0; m < 4; m++)
        begin
            mv(1'b1, 1'b0, IDX_STACK_CTRL, 64'(m), 4'h0);
            `CHK({eager_load_en, eager_store_en}, 2'(m))
        end
        `CHK(spill_priv_level, 2'h0)
        mv(1'b1, 1'b0, IDX_STACK_CTRL, 64'h20, 4'h4);
        mv(1'b1, 1'b0, IDX_STACK_CTRL, 64'h4000_0000, 4'h4);
        rdc(IDX_STACK_CTRL, 64'h3);
    endtask

    // Spill engine pointers, read-only and unmapped places
    task automatic t_spill();
        mv(1'b1, 1'b0, IDX_BACK_SAVE, 64'h1, 4'h2);
        mv(1'b0, 1'b0, 7'h7F, 64'h0, 4'h2);
        back_save_load = 1'b1;
        spill_next_load = 1'b1;
        defer_load = 1'b1;
        @(negedge clk);
        back_save_load = 1'b0;
        spill_next_load = 1'b0;
        defer_load = 1'b0;
        rdc(IDX_BACK_SAVE, 64'hFEDC_BA98_7654_3210);
        `CHK(spill_next_addr, 64'h0000_0000_0000_0C00)
        rdc(IDX_SPILL_DEFER, 64'h7FFF_FFFF_FFFF_FFFF);
        mv(1'b1, 1'b0, IDX_SPILL_NEXT, 64'h8000_0000_0000_0100, 4'h0);
        `CHK(spill_next_addr, 64'h8000_0000_0000_0100)
        mv(1'b1, 1'b0, IDX_SPILL_DEFER, 64'hFFFF_FFFF_FFFF_FFFE, 4'h0);
        rdc(IDX_SPILL_DEFER, 64'h7FFF_FFFF_FFFF_FFFE);
    endtask

    // Wide store and compare value registers
    task automatic t_wide();
        mv(1'b1, 1'b0, IDX_WIDE_STORE, 64'hFFFF_FFFF_FFFF_FFFF, 4'h0);
        `CHK(wide_store_data, 64'hFFFF_FFFF_FFFF_FFFF)
        wide_load_valid = 1'b1;
        @(negedge clk);
        wide_load_valid = 1'b0;
        rdc(IDX_WIDE_STORE, 64'h3000_0000_0000_00C3);
        mv(1'b1, 1'b0, IDX_COMPARE_VAL, 64'h0123_4567_89AB_CDEF, 4'h0);
        `CHK(compare_value, 64'h0123_4567_89AB_CDEF)
    endtask

    // Interval timer rate, ordering, security and wrap
    task automatic t_timer();
        logic [63:0] a;
        cur_priv = 2'h3;
        mv(1'b0, 1'b0, IDX_TIMER, 64'h0, 4'h0);
        `CHK(ar_move_issuer_i.last_data != 64'h0, 1'b1)
        a = ar_move_issuer_i.last_data;
        mv(1'b0, 1'b0, IDX_TIMER, 64'h0, 4'h0);
        `CHK(ar_move_issuer_i.last_data - a, 64'h2)
        mv(1'b1, 1'b0, IDX_TIMER, 64'h0, 4'h8);
        timer_secure = 1'b1;
        mv(1'b0, 1'b0, IDX_TIMER, 64'h0, 4'h8);
        mv(1'b0, 1'b1, IDX_TIMER, 64'h0, 4'h1);
        cur_priv = 2'h0;
        mv(1'b0, 1'b0, IDX_TIMER, 64'h0, 4'h0);
        a = ar_move_issuer_i.last_data;
        mv(1'b0, 1'b1, IDX_TIMER, 64'h0, 4'h0);
        `CHK(ar_move_issuer_i.last_data - a, 64'h2)
        mv(1'b1, 1'b0, IDX_TIMER, 64'hFFFF_FFFF_FFFF_FFFF, 4'h0);
        mv(1'b0, 1'b0, IDX_TIMER, 64'h0, 4'h0);
        `CHK(ar_move_issuer_i.last_data < 64'h10, 1'b1)
        timer_secure = 1'b0;
    endtask

    // Frame descriptor load, call and return
    task automatic t_frame();
        frame_load_value = {20'hABCDE, 4'h3, 7'h05, 7'h14};
        frame_load_valid = 1'b1;
        @(negedge clk);
        frame_load_valid = 1'b0;
        fd_old = frame_descriptor;
        mv(1'b1, 1'b0, IDX_OS_INFO_0, 64'hFFFF_FFFF_FFFF_FFFF, 4'h0);
        `CHK(frame_descriptor, fd_old)
        call_valid = 1'b1;
        @(negedge clk);
        call_valid = 1'b0;
        `CHK(caller_state_reg, {20'hABCDE, 4'h3, 7'h05, 7'h14})
        `CHK(frame_descriptor, {31'h0, 7'h0F})
        ret_valid = 1'b1;
        @(negedge clk);
        ret_valid = 1'b0;
        `CHK(frame_descriptor, {20'hABCDE, 4'h3, 7'h05, 7'h14})
    endtask

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        {cur_priv, legacy_mode, timer_secure, call_valid, ret_valid} = '0;
        {frame_load_valid, frame_load_value, legacy_state_we, legacy_state_wdata} = '0;
        {back_save_load, spill_next_load, defer_load, wide_load_valid} = '0;
        back_save_value = 64'hFEDC_BA98_7654_3210;
        spill_next_value = 64'h0000_0000_0000_0C00;
        defer_value = 64'hFFFF_FFFF_FFFF_FFFF;
        wide_load_upper = 64'h3000_0000_0000_00C3;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        `CHK(frame_descriptor, {FD_WIDTH{1'b0}})
        rdc(IDX_OS_INFO_0, RESET_WORD);
        t_os_info();
        t_ctrl();
        t_spill();
        t_wide();
        t_timer();
        t_frame();
        finish_test();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule
